/* File: rtl/aod_decode.sv */
// Purpose: decodes arithmetic, logical, rotate and pair opcodes
// Assumes: opcode_valid marks a freshly fetched opcode byte
// Notes:   controls are registered one cycle after the fetch

// Notes on behaviour
// RULE1 - register field codes B C D E H L memory A, six is memory at H-L
// RULE2 - pair increment and decrement pick pair by bits 5:4, 6 cycles, no flags
// RULE3 - double add adds a pair to H-L into H-L in 10 cycles
// RULE4 - add and add-with-carry register forms take 4 cycles
// RULE5 - add forms with source six read memory at H-L in 7 cycles
// RULE6 - add immediate and add immediate with carry take 7 cycles
// RULE7 - subtract and subtract-with-borrow register forms take 4 cycles
// RULE8 - subtract forms with source six read memory at H-L in 7 cycles
// RULE9 - subtract immediate forms, with and without borrow, take 7 cycles
// RULE10 - and, xor, or, compare register forms take 4 cycles
// RULE11 - logical forms with source six read memory at H-L in 7 cycles
// RULE12 - and, xor, or immediate forms take 7 cycles
// RULE13 - compare immediate takes 7 cycles
// RULE14 - four accumulator rotates take 4 cycles each
// RULE15 - conditional instructions take short or long count by flag test
// RULE16 - compare sets flags like subtract, accumulator unchanged
// RULE17 - arithmetic and logic set all five flags, rotates only carry
module aod_decode (
	input  wire logic                clock,
	input  wire logic                rst_b,
	input  wire logic                clk_en,
	input  wire logic                opcode_valid,
	input  wire logic [7:0]          opcode,
	input  wire aod_pkg::aod_flags_t flags,
	output aod_pkg::aod_ctrl_t       ctrl,
	output logic                     ctrl_valid
);
	// ------------------------------------------------------------
	// combinational decode
	// ------------------------------------------------------------
	aod_pkg::aod_ctrl_t ctrl_reg;
	aod_pkg::aod_ctrl_t ctrl_next;
	logic               valid_reg;
	logic               valid_next;
	logic               cond_met;
	logic [2:0]         src_f;
	logic [1:0]         rp_f;

	assign src_f = opcode[aod_pkg::SRC_LSB +: 3];
	assign rp_f  = opcode[aod_pkg::RP_LSB +: 2];

	aod_cond u_cond (
		.cond  (opcode[aod_pkg::DST_LSB +: 3]),
		.flags (flags),
		.met   (cond_met)
	);

	function automatic aod_pkg::aod_flags_t all_flags();
		all_flags = '{sign: 1'b1, zero: 1'b1, aux: 1'b1,
			parity: 1'b1, carry: 1'b1};
	endfunction : all_flags

	always_comb
	begin
		ctrl_next         = '0;
		ctrl_next.op      = aod_pkg::AOD_NONE;
		ctrl_next.src     = aod_pkg::SRC_REG;
		ctrl_next.cycles  = aod_pkg::CYC_NONE;
		ctrl_next.src_reg = src_f;
		ctrl_next.pair    = rp_f;
		valid_next        = 1'b0;
		if (opcode_valid)
		begin
			valid_next = 1'b1;
			if (opcode[7:6] == aod_pkg::GRP_ALU)
			begin
				// op order matches bits 5:3 of the opcode
				ctrl_next.op      = aod_pkg::aod_op_t'({1'b0, opcode[5:3]});
				ctrl_next.flag_we = all_flags(); // [RULE17]
				// compare leaves the accumulator alone
				ctrl_next.acc_we  = opcode[5:3] != 3'h7; // [RULE16]
				if (src_f == aod_pkg::REG_MEM) // [RULE1]
				begin
					ctrl_next.src    = aod_pkg::SRC_MEM;
					ctrl_next.cycles = aod_pkg::CYC_MEM; // [RULE5] [RULE8] [RULE11]
				end
				else
					ctrl_next.cycles = aod_pkg::CYC_REG; // [RULE4] [RULE7] [RULE10]
			end
			else if (opcode[7:6] == aod_pkg::GRP_HIGH &&
				opcode[2:0] == aod_pkg::LOW_IMM)
			begin
				ctrl_next.op      = aod_pkg::aod_op_t'({1'b0, opcode[5:3]});
				ctrl_next.src     = aod_pkg::SRC_IMM;
				ctrl_next.flag_we = all_flags();
				ctrl_next.acc_we  = opcode[5:3] != 3'h7; // [RULE13] [RULE16]
				ctrl_next.cycles  = aod_pkg::CYC_IMM; // [RULE6] [RULE9] [RULE12]
			end
			else if (opcode[7:6] == aod_pkg::GRP_HIGH &&
				opcode[2:0] == aod_pkg::LOW_CRET)
			begin
				// conditional return: no ALU work, only its timing
				ctrl_next.cycles = cond_met ? aod_pkg::CYC_CLONG
					: aod_pkg::CYC_CSHRT; // [RULE15]
			end
			else if (opcode[7:6] == aod_pkg::GRP_LOW)
			begin
				if (opcode[3:0] == aod_pkg::LOW_INC ||
					opcode[3:0] == aod_pkg::LOW_DEC)
				begin
					ctrl_next.op = opcode[3] ? aod_pkg::AOD_DCX
						: aod_pkg::AOD_INX;
					ctrl_next.src     = aod_pkg::SRC_PAIR;
					ctrl_next.pair_we = 1'b1;
					ctrl_next.cycles  = aod_pkg::CYC_PAIR; // [RULE2]
				end
				else if (opcode[3:0] == aod_pkg::LOW_DAD)
				begin
					ctrl_next.op            = aod_pkg::AOD_DAD;
					ctrl_next.src           = aod_pkg::SRC_PAIR;
					ctrl_next.hl_we         = 1'b1;
					ctrl_next.flag_we.carry = 1'b1;
					ctrl_next.cycles        = aod_pkg::CYC_DADD; // [RULE3]
				end
				else if (opcode[2:0] == aod_pkg::LOW_ROT &&
					opcode[5] == 1'b0)
				begin
					ctrl_next.op = aod_pkg::aod_op_t'({2'h2, opcode[4:3]});
					ctrl_next.src_reg       = aod_pkg::REG_A;
					ctrl_next.acc_we        = 1'b1;
					ctrl_next.flag_we.carry = 1'b1; // [RULE17]
					ctrl_next.cycles        = aod_pkg::CYC_REG; // [RULE14]
				end
			end
		end
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_reg  <= '{op: aod_pkg::AOD_NONE, src: aod_pkg::SRC_REG,
				default: '0};
			valid_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			ctrl_reg  <= ctrl_next;
			valid_reg <= valid_next;
		end
	end

	assign ctrl       = ctrl_reg;
	assign ctrl_valid = valid_reg;
endmodule : aod_decode

/* File: rtl/aod_pkg.sv */
// Purpose: shared constants and carrier types for the ALU opcode decoder
// Assumes: 8-bit opcodes, flags in sign/zero/aux/parity/carry order
// Notes:   cycle counts are processor clock states per instruction
package aod_pkg;
	// ------------------------------------------------------------
	// register field codes
	// ------------------------------------------------------------
	localparam logic [2:0] REG_B   = 3'h0;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_A   = 3'h7;
	// ------------------------------------------------------------
	// cycle counts
	// ------------------------------------------------------------
	localparam logic [4:0] CYC_REG   = 5'h04;
	localparam logic [4:0] CYC_MEM   = 5'h07;
	localparam logic [4:0] CYC_IMM   = 5'h07;
	localparam logic [4:0] CYC_PAIR  = 5'h06;
	localparam logic [4:0] CYC_DADD  = 5'h0A;
	localparam logic [4:0] CYC_CSHRT = 5'h06;
	localparam logic [4:0] CYC_CLONG = 5'h0C;
	// ------------------------------------------------------------
	// opcode fields
	// ------------------------------------------------------------
	localparam int SRC_LSB = 0;
	localparam int DST_LSB = 3;
	localparam int RP_LSB  = 4;
	localparam logic [1:0] GRP_ALU  = 2'h2;
	localparam logic [1:0] GRP_LOW  = 2'h0;
	localparam logic [1:0] GRP_HIGH = 2'h3;
	localparam logic [3:0] LOW_INC  = 4'h3;
	localparam logic [3:0] LOW_DAD  = 4'h9;
	localparam logic [3:0] LOW_DEC  = 4'hB;
	localparam logic [2:0] LOW_ROT  = 3'h7;
	localparam logic [2:0] LOW_IMM  = 3'h6;
	localparam logic [2:0] LOW_CRET = 3'h0;
	localparam logic [4:0] CYC_NONE = 5'h00;

	typedef enum logic [3:0] {
		AOD_ADD, AOD_ADC, AOD_SUB, AOD_SBB,
		AOD_AND, AOD_XOR, AOD_OR, AOD_CMP,
		AOD_RLC, AOD_RRC, AOD_RAL, AOD_RAR,
		AOD_INX, AOD_DCX, AOD_DAD, AOD_NONE
	} aod_op_t;

	typedef enum logic [1:0] {
		SRC_REG, SRC_MEM, SRC_IMM, SRC_PAIR
	} aod_src_t;

	typedef struct packed {
		logic sign;
		logic zero;
		logic aux;
		logic parity;
		logic carry;
	} aod_flags_t;

	typedef struct packed {
		aod_op_t    op;
		aod_src_t   src;
		logic [2:0] src_reg;
		logic [1:0] pair;
		logic       acc_we;
		logic       hl_we;
		logic       pair_we;
		logic [4:0] cycles;
		aod_flags_t flag_we;
	} aod_ctrl_t;
endpackage : aod_pkg

/* File: rtl/aod_cond.sv */
// Purpose: evaluates a three-bit branch condition against the flags
// Assumes: code order nz z nc c po pe p m
// Notes:   purely combinational
module aod_cond (
	input  wire logic [2:0]          cond,
	input  wire aod_pkg::aod_flags_t flags,
	output logic                     met
);
	always_comb
	begin
		unique case (cond[2:1])
			2'h0:    met = flags.zero ^ ~cond[0];
			2'h1:    met = flags.carry ^ ~cond[0];
			2'h2:    met = flags.parity ^ ~cond[0];
			default: met = flags.sign ^ ~cond[0];
		endcase
	end
endmodule : aod_cond

/* File: dv/aod_decode_properties.sv */
// Purpose: timing and control checks on the opcode decoder
// Assumes: ctrl follows a taken opcode by one edge
// Notes:   ctrl stands while clk_en is low, so |=> holds
module aod_decode_properties (
	input wire logic                clock,
	input wire logic                rst_b,
	input wire logic                clk_en,
	input wire logic                opcode_valid,
	input wire logic [7:0]          opcode,
	input wire aod_pkg::aod_flags_t flags,
	input wire aod_pkg::aod_ctrl_t  ctrl,
	input wire logic                ctrl_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------
	// checks
	// ------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire logic hit = opcode[3] == (opcode[5] ? (opcode[4] ? flags.sign
		: flags.parity) : (opcode[4] ? flags.carry : flags.zero));
	sequence s_take(p);
		clk_en && opcode_valid && p;
	endsequence
	a_reg_cycles : assert property (
		s_take(opcode[7:6] == 2'h2 && opcode[2:0] != 3'h6) |=> ctrl_valid
		&& ctrl.cycles == 5'h04 && ctrl.src_reg == $past(opcode[2:0]))
		else $error("register form count wrong");
	a_mem_cycles : assert property (
		s_take(opcode[7:6] == 2'h2 && opcode[2:0] == 3'h6) |=>
		ctrl.cycles == 5'h07 && ctrl.src == aod_pkg::SRC_MEM)
		else $error("memory form count wrong");
	a_imm_cycles : assert property (
		s_take(opcode[7:6] == 2'h3 && opcode[2:0] == 3'h6) |=>
		ctrl.cycles == 5'h07 && ctrl.src == aod_pkg::SRC_IMM)
		else $error("immediate form count wrong");
	a_pair_step : assert property (
		s_take(opcode[7:6] == 2'h0 && opcode[2:0] == 3'h3) |=>
		ctrl.cycles == 5'h06 && ctrl.flag_we == 5'h00
		&& ctrl.pair == $past(opcode[5:4]))
		else $error("pair step wrong");
	a_dad_count : assert property (
		s_take(opcode[7:6] == 2'h0 && opcode[3:0] == 4'h9) |=>
		ctrl.cycles == 5'h0A && ctrl.hl_we && ctrl.pair == $past(opcode[5:4]))
		else $error("double add wrong");
	a_rot_carry : assert property (
		s_take(opcode[7:5] == 3'h0 && opcode[2:0] == 3'h7) |=>
		ctrl.cycles == 5'h04 && ctrl.flag_we == 5'h01)
		else $error("rotate wrong");
	a_cmp_no_acc : assert property (
		s_take(opcode[7:3] == 5'h17) |=> !ctrl.acc_we && ctrl.flag_we == 5'h1F)
		else $error("compare writes accumulator");
	a_cond_count : assert property (
		s_take(opcode[7:6] == 2'h3 && opcode[2:0] == 3'h0) |=>
		ctrl.cycles == ($past(hit) ? 5'h0C : 5'h06))
		else $error("conditional count wrong");
endmodule : aod_decode_properties

bind aod_decode aod_decode_properties i_aod_decode_properties (
	.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
	.opcode_valid(opcode_valid), .opcode(opcode), .flags(flags),
	.ctrl(ctrl), .ctrl_valid(ctrl_valid));

/* File: dv/aod_seq_model.sv */
// Purpose: bus sequencer stand-in that spends decoded state counts
// Assumes: one count per ctrl_valid pulse
// Notes:   a new count overrides the old one, no queueing
module aod_seq_model (
	input  wire logic               clock,
	input  wire logic               rst_b,
	input  wire logic               ctrl_valid,
	input  wire aod_pkg::aod_ctrl_t ctrl,
	output logic [4:0]              states_left
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
			states_left <= 5'h00;
		else if (ctrl_valid)
			states_left <= ctrl.cycles;
		else if (states_left != 5'h00)
			states_left <= states_left - 5'h01;
endmodule : aod_seq_model

/* File: dv/aod_decode_tb_top.sv */
// Purpose: directed checks of opcode decode and state counts
// Assumes: one edge decode latency
// Notes:   flags driven here, expectations built from opcode fields
module aod_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_b, clk_en, opcode_valid, ctrl_valid;
	logic [7:0] opcode;
	logic [4:0] states_left;
	aod_pkg::aod_flags_t flags;
	aod_pkg::aod_ctrl_t ctrl;
	int err_count, n_tests, cyc;
	aod_decode i_aod_decode (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.opcode_valid(opcode_valid), .opcode(opcode), .flags(flags),
		.ctrl(ctrl), .ctrl_valid(ctrl_valid));
	aod_seq_model i_aod_seq_model (.clock(clock), .rst_b(rst_b),
		.ctrl_valid(ctrl_valid), .ctrl(ctrl), .states_left(states_left));
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		n_tests++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task final_report;
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	// hang guard, far above the ~220 cycles of the run
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			final_report();
		end
	end
	task automatic issue(logic [7:0] o);
		@(posedge clock);
		opcode <= o;
		opcode_valid <= 1'b1;
		@(posedge clock);
		opcode_valid <= 1'b0;
		#1;
	endtask : issue
	task automatic t_alu;
		for (int k = 0; k < 64; k++)
		begin
			issue({2'h2, k[5:0]});
			chk("op", 8'(ctrl.op), 8'(k[5:3]));
			chk("src", 8'(ctrl.src), k[2:0] == 3'h6);
			chk("cyc", 8'(ctrl.cycles), k[2:0] == 3'h6 ? 8'h07 : 8'h04);
			chk("acc", 8'(ctrl.acc_we), k[5:3] != 3'h7);
			chk("vld", 8'(ctrl_valid), 8'h01);
		end
	endtask : t_alu
	task automatic t_imm;
		for (int k = 0; k < 8; k++)
		begin
			issue({2'h3, k[2:0], 3'h6});
			chk("src", 8'(ctrl.src), 8'h02);
			chk("cyc", 8'(ctrl.cycles), 8'h07);
		end
	endtask : t_imm
	task automatic t_pair;
		for (int k = 0; k < 12; k++)
		begin
			issue({2'h0, k[1:0], k < 4 ? 4'h3 : k < 8 ? 4'hB : 4'h9});
			chk("pair", 8'(ctrl.pair), 8'(k[1:0]));
			chk("cyc", 8'(ctrl.cycles), k < 8 ? 8'h06 : 8'h0A);
			chk("pwe", 8'(ctrl.pair_we), k < 8);
			chk("hwe", 8'(ctrl.hl_we), k >= 8);
			// sequencer loads the count one edge after ctrl_valid
			@(posedge clock);
			#1;
			chk("left", 8'(states_left), k < 8 ? 8'h06 : 8'h0A);
		end
	endtask : t_pair
	task automatic t_cond;
		for (int k = 0; k < 16; k++)
		begin
			flags <= {5{k[3]}};
			issue({2'h3, k[2:0], 3'h0});
			chk("cond", 8'(ctrl.cycles), k[3] == k[0] ? 8'h0C : 8'h06);
		end
		issue(8'h1F);
		chk("rot", 8'(ctrl.flag_we), 8'h01);
	endtask : t_cond
	initial
	begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		opcode_valid = 1'b0;
		opcode = 8'h00;
		flags = 5'h00;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		t_alu();
		t_imm();
		t_pair();
		t_cond();
		clk_en <= 1'b0;
		issue(8'h86);
		chk("hold", 8'(ctrl.cycles), 8'h04);
		final_report();
	end
endmodule : aod_decode_tb_top
